// ---- design/eeb_pkg.sv ----
// Constants and types shared by the two-wire EEPROM slave
package eeb_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_HOLD_NS     = 300;
  localparam int HOLD_CYC      = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_WR_MS       = 10;
  localparam int WR_CYC        = (T_WR_MS * 1000000) / CLK_PERIOD_NS;
  localparam int PAGE_DEPTH    = 16;
  localparam int ADDR_W        = 11;
  localparam int BUF_DEPTH     = 2;
  localparam int CTRL_CODE_POS = 7;
  localparam int CS_MSB        = 6;
  localparam int CS_LSB        = 4;
  localparam int BLK_MSB       = 3;
  localparam int BLK_LSB       = 1;
  localparam int RW_POS        = 0;
  localparam logic CTRL_CODE   = 1'b1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RX    = 3'h1,
    ST_ACK   = 3'h3,
    ST_TX    = 3'h2,
    ST_TXACK = 3'h6
  } eeb_state_t;

  typedef enum logic [1:0] {
    KIND_CTRL  = 2'h0,
    KIND_WADDR = 2'h1,
    KIND_DATA  = 2'h2
  } eeb_kind_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } eeb_wr_t;
endpackage

// ---- design/eeb_buf.sv ----
// Two-entry valid/ready buffer between page commit and memory port
`timescale 1ns/1ns
`default_nettype none
module eeb_buf
  import eeb_pkg::*;
#(
  parameter int W = $bits(eeb_wr_t)
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  typedef struct packed {
    logic [BUF_DEPTH-1:0][W-1:0] mem;
    logic                        wr;
    logic                        rd;
    logic [1:0]                  cnt;
  } eeb_buf_st_t;

  eeb_buf_st_t q;
  eeb_buf_st_t n;
  logic        push;
  logic        pop;

  assign in_ready_o  = (q.cnt != 2'(BUF_DEPTH));
  assign out_valid_o = (q.cnt != 2'h0);
  assign out_data_o  = q.mem[q.rd];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wr] = in_data_i;
      n.wr        = ~q.wr;
    end
    if (pop) begin
      n.rd = ~q.rd;
    end
    n.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule
`default_nettype wire

// ---- design/eeb_slave.sv ----
// Two-wire serial EEPROM slave: framing, ack, page buffer, write cycle
// Behaviour
// - Bus is idle while data and clock are both high.
// - Data changes only while clock is low; stable during high phase.
// - Data falling while clock is high is a START.
// - Data rising while clock is high is a STOP.
// - One clock pulse per bit; bit sampled on the clock high phase.
// - Overlong write keeps only the last sixteen bytes, oldest overwritten.
// - Receiver acks each byte by holding data low through the ack pulse.
// - No acks at all while the internal write cycle runs.
// - On master no-ack the device stops sending and releases data.
// - Transmit changes wait a minimum delay after each clock fall.
// - Master makes clock and framing; device is only a slave.
// - Control byte: code bit, chip select (middle inverted), block, direction.
// - Page write increments only the four low pointer bits.
// - STOP ending a write launches the self-timed write cycle.
`timescale 1ns/1ns
`default_nettype none
module eeb_slave
  import eeb_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYC
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              RESET_I,
  input  wire logic              SCL_I,
  input  wire logic              SDA_I,
  output logic                   SDA_O,
  output logic                   SDA_OE_O,
  input  wire logic              CHIP_SELECT_PIN_0_I,
  input  wire logic              CHIP_SELECT_PIN_1_I,
  input  wire logic              CHIP_SELECT_PIN_2_I,
  output logic [ADDR_W-1:0]      RD_ADDR_O,
  input  wire logic [7:0]        RD_DATA_I,
  output logic                   WR_VALID_O,
  input  wire logic              WR_READY_I,
  output eeb_wr_t                WR_DATA_O,
  output logic                   BUSY_O
);
  typedef struct packed {
    logic                       scl_m;
    logic                       scl_s;
    logic                       scl_p;
    logic                       sda_m;
    logic                       sda_s;
    logic                       sda_p;
    logic [2:0]                 cs_m;
    logic [2:0]                 cs_s;
    eeb_state_t                 st;
    eeb_kind_t                  kind;
    logic [3:0]                 bitcnt;
    logic [7:0]                 shreg;
    logic                       rw;
    logic [ADDR_W-1:0]          ptr;
    logic [PAGE_DEPTH-1:0][7:0] page;
    logic [PAGE_DEPTH-1:0]      pvalid;
    logic                       wrpend;
    logic                       busy;
    logic [19:0]                timer;
    logic                       draining;
    logic [3:0]                 drain_idx;
    logic [4:0]                 hold_cnt;
    logic                       pend_low;
    logic                       drv;
  } eeb_slave_st_t;

  eeb_slave_st_t q;
  eeb_slave_st_t n;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_det;
  logic          stop_det;
  logic          push_v;
  logic          push_rdy;
  logic          ctrl_hit;
  eeb_wr_t       push_d;

  assign scl_rise  = q.scl_s & ~q.scl_p;
  assign scl_fall  = ~q.scl_s & q.scl_p;
  // Both lines high, then data falls under high clock
  assign start_det = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop_det  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

  // Address must match straps, middle select bit inverted
  assign ctrl_hit = (q.shreg[CTRL_CODE_POS] == CTRL_CODE)
                  & (q.shreg[CS_MSB:CS_LSB] == {q.cs_s[2], ~q.cs_s[1], q.cs_s[0]});

  assign push_v      = q.draining & q.pvalid[q.drain_idx];
  assign push_d.addr = {q.ptr[ADDR_W-1:4], q.drain_idx};
  assign push_d.data = q.page[q.drain_idx];

  always_comb begin
    n = q;
    n.scl_m = SCL_I;
    n.scl_s = q.scl_m;
    n.scl_p = q.scl_s;
    n.sda_m = SDA_I;
    n.sda_s = q.sda_m;
    n.sda_p = q.sda_s;
    n.cs_m  = {CHIP_SELECT_PIN_2_I, CHIP_SELECT_PIN_1_I, CHIP_SELECT_PIN_0_I};
    n.cs_s  = q.cs_m;

    // Output hold after each clock fall keeps clear of the slow edge
    if (scl_fall) begin
      n.hold_cnt = 5'(HOLD_CYC);
    end else if (q.hold_cnt != 5'h0) begin
      n.hold_cnt = 5'(q.hold_cnt - 5'h1);
    end
    if (q.hold_cnt == 5'h1) begin
      n.drv = q.pend_low;
    end

    case (q.st)
      ST_RX: begin
        if (scl_rise) begin
          n.shreg  = {q.shreg[6:0], q.sda_s};
          n.bitcnt = 4'(q.bitcnt + 4'h1);
        end
        if (scl_fall && q.bitcnt == BITS_PER_BYTE) begin
          n.bitcnt   = 4'h0;
          n.st       = ST_IDLE;
          n.pend_low = 1'b0;
          case (q.kind)
            KIND_CTRL: begin
              if (ctrl_hit && !q.busy) begin
                n.rw                      = q.shreg[RW_POS];
                n.ptr[ADDR_W-1:8]         = q.shreg[BLK_MSB:BLK_LSB];
                n.kind                    = KIND_WADDR;
                n.st                      = ST_ACK;
                n.pend_low                = 1'b1;
                if (!q.shreg[RW_POS]) begin
                  n.pvalid = '0;
                  n.wrpend = 1'b0;
                end
              end
            end
            KIND_WADDR: begin
              n.ptr[7:0] = q.shreg;
              n.kind     = KIND_DATA;
              n.st       = ST_ACK;
              n.pend_low = 1'b1;
            end
            KIND_DATA: begin
              // Pointer wraps in the page, so the oldest entry is overwritten
              n.page[q.ptr[3:0]]   = q.shreg;
              n.pvalid[q.ptr[3:0]] = 1'b1;
              n.wrpend             = 1'b1;
              n.ptr[3:0]           = 4'(q.ptr[3:0] + 4'h1);
              n.st                 = ST_ACK;
              n.pend_low           = 1'b1;
            end
            default: begin
              n.st = ST_IDLE;
            end
          endcase
        end
      end
      ST_ACK: begin
        // Ack is held through the extra pulse; a hold delay after its fall a write releases data, a read drives its first bit
        if (scl_fall) begin
          if (q.rw) begin
            n.st       = ST_TX;
            n.shreg    = RD_DATA_I;
            n.pend_low = ~RD_DATA_I[7];
          end else begin
            n.st       = ST_RX;
            n.pend_low = 1'b0;
          end
        end
      end
      ST_TX: begin
        if (scl_rise) begin
          n.bitcnt = 4'(q.bitcnt + 4'h1);
        end
        if (scl_fall) begin
          if (q.bitcnt == BITS_PER_BYTE) begin
            n.st       = ST_TXACK;
            n.bitcnt   = 4'h0;
            n.pend_low = 1'b0;
            n.ptr      = 11'(q.ptr + 11'h1);
          end else begin
            n.shreg    = {q.shreg[6:0], 1'b0};
            n.pend_low = ~q.shreg[6];
          end
        end
      end
      ST_TXACK: begin
        if (scl_rise && q.sda_s) begin
          n.st = ST_IDLE;
        end else if (scl_fall) begin
          n.st       = ST_TX;
          n.shreg    = RD_DATA_I;
          n.pend_low = ~RD_DATA_I[7];
        end
      end
      ST_IDLE: begin
        n.pend_low = 1'b0;
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // Framing overrides any byte in progress
    if (start_det) begin
      n.st       = ST_RX;
      n.kind     = KIND_CTRL;
      n.bitcnt   = 4'h0;
      n.pend_low = 1'b0;
      n.drv      = 1'b0;
    end else if (stop_det) begin
      n.st       = ST_IDLE;
      n.pend_low = 1'b0;
      n.drv      = 1'b0;
      if (q.wrpend && !q.busy) begin
        n.busy      = 1'b1;
        n.timer     = 20'(WR_CYCLES);
        n.draining  = 1'b1;
        n.drain_idx = 4'h0;
        n.wrpend    = 1'b0;
      end
    end

    // Hand the page to the memory port, stalling on back-pressure
    if (q.draining && (!push_v || push_rdy)) begin
      n.drain_idx = 4'(q.drain_idx + 4'h1);
      if (q.drain_idx == 4'(PAGE_DEPTH - 1)) begin
        n.draining = 1'b0;
      end
    end
    if (q.busy) begin
      if (q.timer != 20'h0) begin
        n.timer = 20'(q.timer - 20'h1);
      end else if (!q.draining && !WR_VALID_O) begin // Busy until the port took every entry
        n.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  eeb_buf #(
    .W ($bits(eeb_wr_t))
  ) u_buf (
    .clk_i       (SYS_CLK_I),
    .rst_i       (RESET_I),
    .in_valid_i  (push_v),
    .in_ready_o  (push_rdy),
    .in_data_i   (push_d),
    .out_valid_o (WR_VALID_O),
    .out_ready_i (WR_READY_I),
    .out_data_o  (WR_DATA_O)
  );
  // Open drain: only ever pull low; the master owns the clock
  assign SDA_O     = 1'b0;
  assign SDA_OE_O  = q.drv;
  assign RD_ADDR_O = q.ptr;
  assign BUSY_O    = q.busy;

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RESET_I);
  start_enters_rx_a: assert property (start_det |=> q.st == ST_RX && q.kind == KIND_CTRL)
    else $error("START did not open control byte reception");
  stop_goes_idle_a: assert property (stop_det |=> q.st == ST_IDLE && !q.drv)
    else $error("STOP did not return to idle");
  busy_no_ack_a: assert property (q.busy && q.st == ST_RX && scl_fall &&
      q.bitcnt == BITS_PER_BYTE && q.kind == KIND_CTRL |=> q.st != ST_ACK && !q.pend_low)
    else $error("Acknowledged while write cycle busy");
  drive_scl_low_a: assert property ($rose(q.drv) |-> !q.scl_s)
    else $error("Data pulled low during clock high");
  hold_delay_a: assert property (scl_fall && !start_det && !stop_det |=> $stable(q.drv) [*8])
    else $error("Data changed too soon after clock fall");
  ack_held_a: assert property (q.st == ST_ACK && scl_rise |-> q.drv)
    else $error("Ack not low during ack clock high");
  nack_release_a: assert property (q.st == ST_TXACK && scl_rise && q.sda_s && !stop_det
      |=> q.st == ST_IDLE && !q.drv)
    else $error("Device kept sending after no-ack");
  stop_commits_a: assert property (stop_det && q.wrpend && !q.busy
      |=> q.busy && q.timer == 20'(WR_CYCLES))
    else $error("STOP after write did not launch write cycle");
  page_wrap_a: assert property (q.st == ST_RX && q.kind == KIND_DATA && scl_fall &&
      q.bitcnt == BITS_PER_BYTE && !start_det && !stop_det
      |=> q.ptr[ADDR_W-1:4] == $past(q.ptr[ADDR_W-1:4])
      && q.ptr[3:0] == 4'($past(q.ptr[3:0]) + 4'h1))
    else $error("Page pointer did not wrap in low four bits");
endmodule
`default_nettype wire

// ---- bench/eeb_master.sv ----
// Behavioural two-wire bus master with device timing monitor
`timescale 1ns/1ns
`default_nettype none
module eeb_master (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sda_i,
  input  wire logic dev_oe_i,
  output logic      scl_o,
  output logic      oe_o
);
  int   bad  = 0;
  int   lo   = 0;
  logic oe_p = 1'b0;
  initial begin
    scl_o = 1'b1;
    oe_o  = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic start();
    wt(24);
    oe_o = 1'b0;
    wt(24);
    scl_o = 1'b1;
    wt(16);
    oe_o = 1'b1;
    wt(16);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    wt(24);
    oe_o = 1'b1;
    wt(24);
    scl_o = 1'b1;
    wt(16);
    oe_o = 1'b0;
    wt(40);
  endtask
  // Data moves mid low phase, sampled at the end of the high phase
  task automatic bx(input logic b, output logic r);
    wt(24);
    oe_o = !b;
    wt(24);
    scl_o = 1'b1;
    wt(16);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bx(d[i], r);
    bx(1'b1, r);
    ack = !r;
  endtask
  task automatic rb(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bx(1'b1, d[i]);
    bx(!mack, r);
  endtask
  // Device may only move the line while clock is low, after the hold delay
  always @(posedge clk_i) begin
    lo   <= scl_o ? 0 : lo + 1;
    oe_p <= dev_oe_i;
    if (!rst_i && dev_oe_i !== oe_p && (scl_o || lo < 30)) begin
      bad <= bad + 1;
      $display("ERROR %0t device moved data outside its window", $time);
    end
  end
endmodule
`default_nettype wire

// ---- bench/eeb_slave_test.sv ----
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/1ns
`default_nettype none
module eeb_slave_test;
  import eeb_pkg::*;
  localparam int WRC = 200;
  logic              clk   = 1'b0;
  logic              rst   = 1'b1;
  logic              rgate = 1'b0;
  logic [2:0]        pins  = 3'h5;
  logic [1:0]        rc    = 2'h0;
  logic              scl, m_oe, sda_o, sda_oe, wr_valid, busy;
  logic [ADDR_W-1:0] rd_addr;
  eeb_wr_t           wr_data;
  eeb_wr_t           wq[$];
  int                err_total = 0;
  int                compares  = 0;
  wire logic         sda = !(sda_oe | m_oe);
  wire logic         rdy = rgate & rc[1];
  always #5 clk = ~clk;
  always @(negedge clk) rc <= rc + 2'h1;
  always @(posedge clk) if (wr_valid && rdy) wq.push_back(wr_data);
  eeb_slave #(.WR_CYCLES(WRC)) dut (
    .SYS_CLK_I(clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .CHIP_SELECT_PIN_0_I(pins[0]),
    .CHIP_SELECT_PIN_1_I(pins[1]), .CHIP_SELECT_PIN_2_I(pins[2]),
    .RD_ADDR_O(rd_addr), .RD_DATA_I(rd_addr[7:0] ^ 8'h5A),
    .WR_VALID_O(wr_valid), .WR_READY_I(rdy), .WR_DATA_O(wr_data),
    .BUSY_O(busy)
  );
  eeb_master m (
    .clk_i(clk), .rst_i(rst), .sda_i(sda), .dev_oe_i(sda_oe), .scl_o(scl), .oe_o(m_oe)
  );
  task automatic ckb(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic ckv(input logic [18:0] got, input logic [18:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] ctl(input logic [2:0] blk, input logic rw);
    return {CTRL_CODE, pins[2], ~pins[1], pins[0], blk, rw};
  endfunction
  task automatic s_refuse();
    logic a;
    m.start();
    m.wb(ctl(3'h2, 1'b0) & 8'h7F, a);
    ckb(a, 1'b0);
    m.start();
    m.wb(ctl(3'h2, 1'b0) ^ 8'h20, a);
    ckb(a, 1'b0);
    m.start();
    m.wb(ctl(3'h2, 1'b0), a);
    ckb(a, 1'b1);
    m.stop();
  endtask
  // Eighteen bytes from offset E: the page keeps bytes 2..17
  task automatic s_page();
    logic a;
    m.start();
    m.wb(ctl(3'h5, 1'b0), a);
    ckb(a, 1'b1);
    m.wb(8'h3E, a);
    ckb(a, 1'b1);
    for (int i = 0; i < 18; i++) begin
      m.wb(8'h40 + 8'(i), a);
      ckb(a, 1'b1);
    end
    m.stop();
    ckb(busy, 1'b1);
    m.start();
    m.wb(ctl(3'h5, 1'b0), a);
    ckb(a, 1'b0);
    m.stop();
    rgate = 1'b1;
    for (int n = 0; n < 2000 && busy === 1'b1; n++) @(negedge clk);
    ckb(busy, 1'b0);
    ckv(19'(wq.size()), 19'h10);
    for (int i = 0; i < 16 && i < wq.size(); i++)
      ckv(wq[i], {11'h530 + 11'(i), 8'h42 + 8'(i)});
  endtask
  task automatic s_read();
    logic       a;
    logic [7:0] d;
    m.start();
    m.wb(ctl(3'h5, 1'b0), a);
    ckb(a, 1'b1);
    m.wb(8'hFF, a);
    ckb(a, 1'b1);
    m.start();
    m.wb(ctl(3'h5, 1'b1), a);
    ckb(a, 1'b1);
    ckb(sda_o, 1'b0);
    m.rb(1'b1, d);
    ckv(19'(d), 19'hA5);
    m.rb(1'b0, d);
    ckv(19'(d), 19'h5A);
    m.wt(40);
    ckb(sda_oe, 1'b0);
    ckb(sda, 1'b1);
    m.stop();
  endtask
  task automatic complete_run();
    err_total += m.bad;
    $display("Comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    m.wt(4);
    s_refuse();
    s_page();
    s_read();
    complete_run();
  end
endmodule
`default_nettype wire
